// [conv_pkg.sv]
/*
 Constants for the converter trigger and result capture controller.
 Assumes a 100 MHz mclk; the trigger high and low times are converted to cycle counts here.
*/
`default_nettype none
package conv_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W = 12;
  localparam int TRIG_HIGH_MIN_NS = 20;
  localparam int TRIG_HIGH_MAX_NS = 50;
  localparam int TRIG_LOW_MIN_NS = 20;
  localparam int FALL_DELAY_MIN_NS = 0;
  localparam int RESTART_DELAY_MIN_NS = 0;
  localparam int TRIG_HIGH_CYC =
    (TRIG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int TRIG_HIGH_MAX_CYC = TRIG_HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int TRIG_LOW_CYC =
    (TRIG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int CNT_W = 4;
  localparam logic [3:0] TRIG_HIGH_CNT = 4'(TRIG_HIGH_CYC - 1);
  localparam logic [3:0] TRIG_LOW_CNT = 4'(TRIG_LOW_CYC - 1);
  localparam logic [11:0] RESULT_RST = 12'h000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b100
  } trig_state_e;
endpackage
`default_nettype wire

// [pin_sync.sv]
/*
 Three-stage input synchroniser with agreement filter.
 Assumes an asynchronous input pin and a single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic pin,
  output logic level
);
  logic [2:0] st_q;
  logic [2:0] st_d;
  logic lvl_q;
  logic lvl_d;

  // The first stage feeds only the second so metastability stays contained.
  always_comb begin
    st_d = {st_q[1:0], pin};
    lvl_d = lvl_q;
    if (st_q[1] == st_q[2]) begin
      lvl_d = st_q[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule
`default_nettype wire

// [conv_ctrl.sv]
/*
 Host controller that pulses the conversion trigger and latches results.
 Assumes the converter pins connect directly; strobe and data are
 asynchronous to mclk and pass through synchronisers.
*/
// Notes on behaviour
// - The trigger stays high at least 20 ns and at most 50 ns.
// - The trigger stays low at least 20 ns between pulses.
// - A rising result-ready edge marks fresh data to latch.
// - A falling result-ready edge still shows the previous result.
// - No wait is needed for the trigger fall against the strobe.
// - A new conversion may follow the previous one back to back.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl (
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire logic twos_comp,
  input wire logic [11:0] data_pins,
  input wire logic msb_n_pin,
  input wire logic over_range_flag,
  input wire logic result_ready_strobe,
  output logic encode,
  output logic busy,
  output logic [11:0] result,
  output logic result_over_range,
  output logic result_valid,
  output logic [11:0] prev_result,
  output logic prev_valid
);
  conv_pkg::trig_state_e st_q;
  conv_pkg::trig_state_e st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic enc_q;
  logic enc_d;
  logic rdy_lvl;
  logic rdy_q;
  logic [11:0] res_q;
  logic [11:0] res_d;
  logic ovr_q;
  logic ovr_d;
  logic val_q;
  logic val_d;
  logic [11:0] prv_q;
  logic [11:0] prv_d;
  logic pval_q;
  logic pval_d;
  logic [11:0] dsy1_q;
  logic [11:0] dsy2_q;
  logic [11:0] dsy3_q;
  logic [11:0] dsy4_q;
  logic [1:0] fsy1_q;
  logic [1:0] fsy2_q;
  logic [1:0] fsy3_q;
  logic [1:0] fsy4_q;

  pin_sync pin_sync_inst (
    .mclk(mclk),
    .srst(srst),
    .pin(result_ready_strobe),
    .level(rdy_lvl)
  );

  // Pin bit 1 sits at index 11 so result reads as a plain binary word.
  function automatic logic [11:0] format_word(input logic [11:0] w,
                                              input logic inv_msb,
                                              input logic tc);
    format_word = tc ? {inv_msb, w[10:0]} : w;
  endfunction

  // Trigger pulse generation; back-to-back starts are allowed after the
  // low time, since no extra wait follows the strobe sequence.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    enc_d = enc_q;
    case (st_q)
      conv_pkg::ST_IDLE: begin
        if (start) begin
          st_d = conv_pkg::ST_HIGH;
          enc_d = 1'b1;
          cnt_d = conv_pkg::TRIG_HIGH_CNT;
        end
      end
      conv_pkg::ST_HIGH: begin
        if (cnt_q == 4'h0) begin
          st_d = conv_pkg::ST_LOW;
          enc_d = 1'b0;
          cnt_d = conv_pkg::TRIG_LOW_CNT;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      conv_pkg::ST_LOW: begin
        if (cnt_q == 4'h0) begin
          st_d = conv_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        st_d = conv_pkg::ST_IDLE;
        enc_d = 1'b0;
        cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= conv_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      enc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      enc_q <= enc_d;
    end
  end

  // Data and flags run four stages deep, matching the strobe path, so the
  // word latched on an edge was sampled within one cycle of the pin edge.
  // Sampling later would miss the 20 ns hold after the strobe falls.
  always_ff @(posedge mclk) begin
    if (srst) begin
      dsy1_q <= conv_pkg::RESULT_RST;
      dsy2_q <= conv_pkg::RESULT_RST;
      dsy3_q <= conv_pkg::RESULT_RST;
      dsy4_q <= conv_pkg::RESULT_RST;
      fsy1_q <= 2'h0;
      fsy2_q <= 2'h0;
      fsy3_q <= 2'h0;
      fsy4_q <= 2'h0;
    end else begin
      dsy1_q <= data_pins;
      dsy2_q <= dsy1_q;
      dsy3_q <= dsy2_q;
      dsy4_q <= dsy3_q;
      fsy1_q <= {over_range_flag, msb_n_pin};
      fsy2_q <= fsy1_q;
      fsy3_q <= fsy2_q;
      fsy4_q <= fsy3_q;
    end
  end

  always_comb begin
    res_d = res_q;
    ovr_d = ovr_q;
    val_d = 1'b0;
    prv_d = prv_q;
    pval_d = 1'b0;
    if (rdy_lvl && !rdy_q) begin
      res_d = format_word(dsy4_q, fsy4_q[0], twos_comp);
      ovr_d = fsy4_q[1];
      val_d = 1'b1;
    end
    if (!rdy_lvl && rdy_q) begin
      prv_d = format_word(dsy4_q, fsy4_q[0], twos_comp);
      pval_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdy_q <= 1'b0;
      res_q <= conv_pkg::RESULT_RST;
      ovr_q <= 1'b0;
      val_q <= 1'b0;
      prv_q <= conv_pkg::RESULT_RST;
      pval_q <= 1'b0;
    end else begin
      rdy_q <= rdy_lvl;
      res_q <= res_d;
      ovr_q <= ovr_d;
      val_q <= val_d;
      prv_q <= prv_d;
      pval_q <= pval_d;
    end
  end

  logic busy_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d != conv_pkg::ST_IDLE);
    end
  end

  assign encode = enc_q;
  assign busy = busy_q;
  assign result = res_q;
  assign result_over_range = ovr_q;
  assign result_valid = val_q;
  assign prev_result = prv_q;
  assign prev_valid = pval_q;
endmodule
`default_nettype wire

// [conv_ctrl_asserts.sv]
/* Port checker for conv_ctrl.
   Assumes one mclk domain; bound in from the bench. */
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire logic encode,
  input wire logic busy,
  input wire logic [11:0] result,
  input wire logic result_over_range,
  input wire logic result_valid,
  input wire logic [11:0] prev_result,
  input wire logic prev_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_tk; start && !busy |=> encode && busy; endproperty
  a_tk: assert property (p_tk) else $error("start lost");
  property p_hi; $rose(encode) |-> encode[*3] ##1 !encode; endproperty
  a_hi: assert property (p_hi) else $error("high time");
  property p_lo; $fell(encode) |-> !encode[*3]; endproperty
  a_lo: assert property (p_lo) else $error("low time");
  property p_bz; $rose(encode) |-> busy[*6]; endproperty
  a_bz: assert property (p_bz) else $error("busy short");
  property p_rv; result_valid |=> !result_valid; endproperty
  a_rv: assert property (p_rv) else $error("long pulse");
  property p_pv; prev_valid |=> !prev_valid; endproperty
  a_pv: assert property (p_pv) else $error("long pulse");
  property p_rs; !result_valid |-> $stable({result_over_range, result});
  endproperty
  a_rs: assert property (p_rs) else $error("result moved");
  property p_ps; !prev_valid |-> $stable(prev_result); endproperty
  a_ps: assert property (p_ps) else $error("prev moved");
  c_rv: cover property (result_valid);
  c_pv: cover property (prev_valid);
  c_held: cover property (start && busy);
endmodule
`default_nettype wire

// [conv_model.sv]
/* Converter model on the pins of conv_ctrl.
   Assumes code and ovr are set before each trigger rise. */
`timescale 1ns/1ps
`default_nettype none
module conv_model (
  input wire logic encode,
  input wire logic [11:0] code,
  input wire logic ovr,
  output logic [11:0] data_pins,
  output logic msb_n_pin,
  output logic over_range_flag,
  output logic result_ready_strobe
);
  logic [12:0] s;
  initial {over_range_flag, msb_n_pin, data_pins} = 14'h0000;
  initial result_ready_strobe = 1'b0;
  always @(posedge encode) begin
    s = {ovr, code};
    // The odd offset keeps every pin edge clear of an mclk edge.
    #303 data_pins = s[11:0];
    msb_n_pin = ~s[11];
    over_range_flag = s[12];
    #20 result_ready_strobe = 1'b1;
    // Over-range cases also take the slow strobe, to cover both widths.
    #(s[12] ? 300 : 150) result_ready_strobe = 1'b0;
    #20 {over_range_flag, msb_n_pin, data_pins} = ~{s[12], ~s[11], s[11:0]};
  end
endmodule
`default_nettype wire

// [conv_ctrl_bench.sv]
/* Bench for conv_ctrl driving the converter model.
   Assumes the model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_bench;
  logic mclk = 1'b0, srst = 1'b1, start = 1'b0, twos_comp = 1'b0;
  logic ovr = 1'b0, msb_n_pin, over_range_flag, result_ready_strobe;
  logic encode, busy, result_over_range, result_valid, prev_valid;
  logic [11:0] code = 12'h000, data_pins, result, prev_result;
  int err_total = 0, checked = 0, cyc = 0;
  always #5 mclk = ~mclk;
  conv_model conv_model_inst (.encode, .code, .ovr, .data_pins, .msb_n_pin,
    .over_range_flag, .result_ready_strobe);
  conv_ctrl conv_ctrl_inst (.mclk, .srst, .start, .twos_comp, .data_pins,
    .msb_n_pin, .over_range_flag, .result_ready_strobe, .encode, .busy,
    .result, .result_over_range, .result_valid, .prev_result, .prev_valid);
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic conv(input logic [11:0] c, input logic o, input logic t);
    logic [12:0] e;
    int n;
    e = {o, t ? ~c[11] : c[11], c[10:0]};
    @(negedge mclk);
    code = c;
    ovr = o;
    twos_comp = t;
    start = 1'b1;
    @(negedge mclk);
    // A second cycle of start arrives while busy and must be refused.
    @(negedge mclk);
    start = 1'b0;
    for (n = 0; n < 200 && result_valid !== 1'b1; n++) @(negedge mclk);
    chk({result_over_range, result}, e);
    for (n = 0; n < 200 && prev_valid !== 1'b1; n++) @(negedge mclk);
    chk({1'b0, prev_result}, {1'b0, e[11:0]});
  endtask
  task automatic t_plain; conv(12'hA53, 1'b0, 1'b0); endtask
  task automatic t_twos; conv(12'h801, 1'b1, 1'b1); endtask
  task automatic t_top; conv(12'hFFF, 1'b0, 1'b1); endtask
  task automatic t_zero; conv(12'h000, 1'b1, 1'b0); endtask
  initial begin
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    t_plain();
    t_twos();
    t_top();
    t_zero();
    end_of_test();
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      end_of_test();
    end
  end
endmodule
bind conv_ctrl conv_ctrl_asserts conv_ctrl_asserts_inst (.mclk, .srst,
  .start, .encode, .busy, .result, .result_over_range, .result_valid,
  .prev_result, .prev_valid);
`default_nettype wire
